// ### inc/pmw_pkg.sv
// package for the power mode and wake-up controller
// assumes one 200 MHz clock and synchronous active-high reset
package pmw_pkg;
  localparam logic [2:0] CLK_SEL_SUB      = 3'h7;
  localparam logic [2:0] CLK_SEL_RESET    = 3'h0;
  // one-hot divisor: bit k divides by two to the k, so /64 needs bit 6
  localparam int         DIV_W            = 7;
  localparam int         CLK_PERIOD_PS    = 5000;
  // oscillator settle times in nanoseconds
  localparam int         HS_SETTLE_NS     = 20000;
  localparam int         LS_SETTLE_NS     = 1000;
  localparam int         HS_SETTLE_CYC    =
    (HS_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int         LS_SETTLE_CYC    =
    (LS_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int         CNT_W            = 16;
  localparam int         PORTA_W          = 4;

  typedef enum logic [5:0] {
    ST_FAST  = 6'h01,
    ST_SLOW  = 6'h02,
    ST_SLEEP = 6'h04,
    ST_IDLE0 = 6'h08,
    ST_IDLE1 = 6'h10,
    ST_IDLE2 = 6'h20
  } mode_type;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
    logic sys_on;
    logic sys_is_sub;
  } clk_en_type;

  typedef struct packed {
    logic pc_sp_reset;
    logic take_irq;
    logic resume;
  } wake_act_type;
endpackage : pmw_pkg

// ### src/power_mode_wake_control.sv
// power mode controller: fast/slow clock select, halt modes and wake-up
// assumes core gives one-cycle halt/clear pulses; porta pins are async
// Overview of operation
// - select code 111 while fast moves the system clock to sub clock
// - codes 000 to 110 select high clock divided by one to sixty-four
// - halt with both keep bits low enters sleep, only watchdog runs
// - halt with hs keep low, ls keep high enters idle0
// - halt with both keep bits high enters idle1, both clocks run
// - halt with hs keep high, ls keep low enters idle2
// - every halt mode stops the program while state is preserved
// - halt sets the power-down flag and clears the watchdog timeout flag
// - entering a halt mode clears the watchdog counter, which keeps going
// - power-down flag clears only on power-up or watchdog clear instruction
// - wake on enabled porta falling edge, interrupt or watchdog overflow
// - watchdog wake sets timeout flag and resets only pc and sp
// - each porta pin has a wake enable; resume after halt instruction
// - disabled irq or full stack wake resumes after halt, irq stays pending
// - enabled irq with free stack takes the normal interrupt response
// - irq already pending at halt entry cannot wake the device
// - returning fast with oscillator off reports via hs stable flag
// - switch into slow completes only once slow oscillator is stable
// - hs enable or frequency change clears stable flag then sets it
// - select 000 undivided, power-of-two steps, 111 the sub clock
`timescale 1ns/1ps
module power_mode_wake_control
  import pmw_pkg::*;
#(
  parameter int PA_W       = PORTA_W,
  parameter int HS_SETTLE  = HS_SETTLE_CYC,
  parameter int LS_SETTLE  = LS_SETTLE_CYC
) (
  // clock and reset
  input  wire logic            mclk_i,
  input  wire logic            srst_i,
  // configuration
  input  wire logic [2:0]      sys_clk_sel_i,
  input  wire logic            hs_osc_keep_on_halt_i,
  input  wire logic            ls_osc_keep_on_halt_i,
  input  wire logic            hs_osc_enable_i,
  input  wire logic            hs_freq_change_i,
  input  wire logic [PA_W-1:0] porta_wake_enable_i,
  input  wire logic [PA_W-1:0] porta_pin_i,
  // core, interrupt controller and watchdog
  input  wire logic            halt_instr_i,
  input  wire logic            watchdog_clear_instr_i,
  input  wire logic            irq_req_i,
  input  wire logic            irq_enabled_i,
  input  wire logic            stack_full_i,
  input  wire logic            wdt_overflow_i,
  // status and control outputs
  output logic [5:0]           mode_o,
  output logic                 cpu_run_o,
  output logic                 hs_osc_on_o,
  output logic                 ls_osc_on_o,
  output logic                 sys_clk_en_o,
  output logic                 sys_is_sub_o,
  output logic [DIV_W-1:0]     div_sel_o,
  output logic                 hs_osc_stable_flag_o,
  output logic                 power_down_flag_o,
  output logic                 wdt_timeout_flag_o,
  output logic                 wdt_clear_o,
  output logic                 pc_sp_reset_o,
  output logic                 irq_take_o,
  output logic                 resume_o
);

  mode_type         mode;
  mode_type         next_mode;
  logic [PA_W-1:0]  pa_s1, pa_s2, pa_s3, pa_lvl;
  logic             irq_armed;
  logic             ls_stable;
  logic             hs_stable;
  logic [CNT_W-1:0] hs_cnt;
  logic [CNT_W-1:0] ls_cnt;
  logic             hs_run_prev;
  logic             restart_wait;
  logic             wake_pend;
  wake_act_type     wake_act;
  clk_en_type       clk_en;

  // decoding used for halt entry and the clock table
  function automatic mode_type halt_target(input logic hk, input logic lk);
    case ({hk, lk})
      2'b00:   halt_target = ST_SLEEP;
      2'b01:   halt_target = ST_IDLE0;
      2'b11:   halt_target = ST_IDLE1;
      default: halt_target = ST_IDLE2;
    endcase
  endfunction : halt_target

  function automatic logic is_halt(input mode_type m);
    is_halt = (m == ST_SLEEP) || (m == ST_IDLE0) ||
              (m == ST_IDLE1) || (m == ST_IDLE2);
  endfunction : is_halt

  wire       in_halt   = is_halt(mode);
  wire       run_mode  = !in_halt;
  wire       want_sub  = (sys_clk_sel_i == CLK_SEL_SUB);
  // a fall counts once stages two and three agree low against the held level
  wire [PA_W-1:0] pa_fall = pa_lvl & ~pa_s2 & ~pa_s3 &
                            porta_wake_enable_i;
  wire       pa_wake   = in_halt && (|pa_fall);
  wire       irq_wake  = in_halt && irq_req_i && irq_armed;
  wire       wdt_wake  = in_halt && wdt_overflow_i;
  wire       any_wake  = pa_wake || irq_wake || wdt_wake;
  wire       halt_go   = run_mode && halt_instr_i && !restart_wait;
  wire       hs_needed = (mode == ST_FAST) || (mode == ST_IDLE1) ||
                         (mode == ST_IDLE2) ||
                         ((mode == ST_SLOW) && hs_osc_enable_i);
  wire       ls_needed = (mode != ST_SLEEP) && (mode != ST_IDLE2);
  wire       hs_restart = hs_needed && !hs_run_prev;

  // mode sequencing
  always_comb begin
    next_mode = mode;
    case (mode)
      ST_FAST: begin
        if (halt_go)
          next_mode = halt_target(hs_osc_keep_on_halt_i,
                                  ls_osc_keep_on_halt_i);
        else if (want_sub && ls_stable)
          next_mode = ST_SLOW;
      end
      ST_SLOW: begin
        if (halt_go)
          next_mode = halt_target(hs_osc_keep_on_halt_i,
                                  ls_osc_keep_on_halt_i);
        else if (!want_sub)
          next_mode = ST_FAST;
      end
      ST_SLEEP, ST_IDLE0, ST_IDLE1, ST_IDLE2: begin
        if (any_wake)
          next_mode = want_sub ? ST_SLOW : ST_FAST;
      end
      default: next_mode = ST_FAST;
    endcase
  end

  // clock enables per mode
  assign clk_en.hs_on      = hs_needed;
  assign clk_en.ls_on      = ls_needed;
  assign clk_en.sys_on     = run_mode && !restart_wait && !halt_go;
  assign clk_en.sys_is_sub = (mode == ST_SLOW);

  assign wake_act.pc_sp_reset = wdt_wake;
  assign wake_act.take_irq    = irq_wake && !wdt_wake && irq_enabled_i &&
                                !stack_full_i;
  assign wake_act.resume      = any_wake && !wake_act.pc_sp_reset &&
                                !wake_act.take_irq;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pa_s1 <= '1;
      pa_s2 <= '1;
      pa_s3 <= '1;
      pa_lvl <= '1;
    end else begin
      pa_s1 <= porta_pin_i;
      pa_s2 <= pa_s1;
      pa_s3 <= pa_s2;
      pa_lvl <= (pa_s2 & pa_s3) | (pa_lvl & (pa_s2 | pa_s3));
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i)
      mode <= ST_FAST;
    else
      mode <= next_mode;
  end

  // interrupt wake arming is sampled at halt entry
  always_ff @(posedge mclk_i) begin
    if (srst_i)
      irq_armed <= 1'b0;
    else if (halt_go)
      irq_armed <= !irq_req_i;
    else if (in_halt && !irq_req_i)
      irq_armed <= irq_armed;
  end

  // oscillator settle counters; hs counter restarts on enable or retune
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      hs_cnt      <= '0;
      hs_stable   <= 1'b0;
      hs_run_prev <= 1'b0;
    end else begin
      hs_run_prev <= hs_needed;
      if (!hs_needed || hs_restart || hs_freq_change_i) begin
        hs_cnt    <= '0;
        hs_stable <= 1'b0;
      end else if (hs_cnt == CNT_W'(HS_SETTLE - 1)) begin
        hs_stable <= 1'b1;
      end else if (!hs_stable) begin
        hs_cnt <= hs_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ls_cnt    <= '0;
      ls_stable <= 1'b0;
    end else if (ls_cnt == CNT_W'(LS_SETTLE - 1)) begin
      ls_stable <= 1'b1;
    end else begin
      ls_cnt <= ls_cnt + 1'b1;
    end
  end

  // after wake the core waits for hs stable if fast, else for ls stable, which only settles once after reset
  always_ff @(posedge mclk_i) begin
    if (srst_i)
      restart_wait <= 1'b0;
    else if (in_halt && any_wake)
      restart_wait <= 1'b1;
    else if (restart_wait && (mode == ST_SLOW ? ls_stable : hs_stable))
      restart_wait <= 1'b0;
  end

  // flags: the halt set wins over a coincident watchdog clear
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      power_down_flag_o  <= 1'b0;
      wdt_timeout_flag_o <= 1'b0;
    end else begin
      if (halt_go)
        power_down_flag_o <= 1'b1;
      else if (watchdog_clear_instr_i)
        power_down_flag_o <= 1'b0;
      if (wdt_wake)
        wdt_timeout_flag_o <= 1'b1;
      else if (halt_go)
        wdt_timeout_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mode_o       <= ST_FAST;
      cpu_run_o    <= 1'b0;
      hs_osc_on_o  <= 1'b0;
      ls_osc_on_o  <= 1'b0;
      sys_clk_en_o <= 1'b0;
      sys_is_sub_o <= 1'b0;
      div_sel_o    <= '0;
      hs_osc_stable_flag_o <= 1'b0;
      wdt_clear_o  <= 1'b0;
      pc_sp_reset_o <= 1'b0;
      irq_take_o   <= 1'b0;
      resume_o     <= 1'b0;
    end else begin
      mode_o       <= next_mode;
      cpu_run_o    <= clk_en.sys_on;
      hs_osc_on_o  <= clk_en.hs_on;
      ls_osc_on_o  <= clk_en.ls_on;
      sys_clk_en_o <= clk_en.sys_on;
      sys_is_sub_o <= clk_en.sys_is_sub;
      div_sel_o    <= want_sub ? '0 :
                      DIV_W'(1) << sys_clk_sel_i;
      hs_osc_stable_flag_o <= hs_stable;
      wdt_clear_o  <= halt_go;
      pc_sp_reset_o <= wake_act.pc_sp_reset;
      irq_take_o   <= wake_act.take_irq;
      resume_o     <= wake_act.resume;
    end
  end

  property p_halt_flags;
    @(posedge mclk_i) disable iff (srst_i)
    halt_go |=> power_down_flag_o && !wdt_timeout_flag_o;
  endproperty
  a_halt_flags: assert property (p_halt_flags)
    else $error("halt did not set power-down and clear timeout");

  property p_sleep_entry;
    @(posedge mclk_i) disable iff (srst_i)
    halt_go && !hs_osc_keep_on_halt_i && !ls_osc_keep_on_halt_i
      |=> mode == ST_SLEEP ##1 !hs_osc_on_o && !ls_osc_on_o;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entry wrong");

  property p_idle1_entry;
    @(posedge mclk_i) disable iff (srst_i)
    halt_go && hs_osc_keep_on_halt_i && ls_osc_keep_on_halt_i
      |=> mode == ST_IDLE1 ##1 hs_osc_on_o && ls_osc_on_o;
  endproperty
  a_idle1_entry: assert property (p_idle1_entry)
    else $error("idle1 entry wrong");

  property p_halt_stops_cpu;
    @(posedge mclk_i) disable iff (srst_i)
    halt_go || in_halt |=> !cpu_run_o && !sys_clk_en_o;
  endproperty
  a_halt_stops_cpu: assert property (p_halt_stops_cpu)
    else $error("cpu runs in halt mode");

  property p_wdt_clear;
    @(posedge mclk_i) disable iff (srst_i)
    halt_go |=> wdt_clear_o ##1 !wdt_clear_o || halt_go;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear)
    else $error("watchdog not cleared on halt");

  property p_pdf_hold;
    @(posedge mclk_i) disable iff (srst_i)
    !watchdog_clear_instr_i && power_down_flag_o |=> power_down_flag_o;
  endproperty
  a_pdf_hold: assert property (p_pdf_hold)
    else $error("pdf cleared without clear instruction");

  property p_wdt_wake;
    @(posedge mclk_i) disable iff (srst_i)
    wdt_wake |=> wdt_timeout_flag_o && pc_sp_reset_o && !is_halt(mode);
  endproperty
  a_wdt_wake: assert property (p_wdt_wake)
    else $error("watchdog wake wrong");

  property p_no_wake_run;
    @(posedge mclk_i) disable iff (srst_i)
    run_mode |=> !resume_o && !irq_take_o && !pc_sp_reset_o;
  endproperty
  a_no_wake_run: assert property (p_no_wake_run)
    else $error("wake action outside halt");

  property p_irq_take;
    @(posedge mclk_i) disable iff (srst_i)
    irq_wake && !wdt_wake && irq_enabled_i && !stack_full_i |=> irq_take_o;
  endproperty
  a_irq_take: assert property (p_irq_take)
    else $error("enabled irq wake not taken");

  property p_slow_needs_ls;
    @(posedge mclk_i) disable iff (srst_i)
    mode == ST_FAST && next_mode == ST_SLOW |-> ls_stable && want_sub;
  endproperty
  a_slow_needs_ls: assert property (p_slow_needs_ls)
    else $error("slow entered before ls stable");

endmodule : power_mode_wake_control

// ### tb/core_model.sv
// partner model: core halt and clear pulses and watchdog overflow pulses
// assumes the bench calls its tasks from a single process
`timescale 1ns/1ps
module core_model (
  // clock and status from the block
  input  wire logic mclk_i,
  input  wire logic cpu_run_i,
  input  wire logic hs_stable_i,
  // requests to the block
  output logic      halt_o,
  output logic      clr_o,
  output logic      ovf_o
);
  initial begin
    halt_o = 1'b0;
    clr_o  = 1'b0;
    ovf_o  = 1'b0;
  end
  // software only runs once the core is up on a settled fast clock
  task automatic ready();
    int n;
    n = 0;
    while (!(cpu_run_i === 1'b1 && hs_stable_i === 1'b1) &&
           n < 300) begin
      @(posedge mclk_i);
      n++;
    end
    @(posedge mclk_i);
    #1;
  endtask : ready
  task automatic halt();
    ready();
    halt_o = 1'b1;
    @(posedge mclk_i);
    #1 halt_o = 1'b0;
  endtask : halt
  task automatic clr();
    ready();
    clr_o = 1'b1;
    @(posedge mclk_i);
    #1 clr_o = 1'b0;
  endtask : clr
  // overflow arrives whether or not the core runs
  task automatic ovf();
    ovf_o = 1'b1;
    @(posedge mclk_i);
    #1 ovf_o = 1'b0;
  endtask : ovf
endmodule : core_model

// ### tb/power_mode_wake_control_test.sv
// self-checking bench for the power mode and wake-up controller
// assumes short settle parameters; wake results are checked from a queue
`timescale 1ns/1ps
module power_mode_wake_control_test;
  import pmw_pkg::*;
  localparam int HS = 8;
  localparam int LS = 4;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [2:0] sel;
  logic hk, lk, hen, fchg, irq, ien, sfull, halt, clr, ovf;
  logic [3:0] wen, pin;
  logic [5:0] mode;
  logic run, hon, lon, cen, sub, stb, pdn, tmo, wclr, pcsp, take, res;
  logic [DIV_W-1:0] div;
  logic [1:0] p, q;
  logic [31:0] rng = 32'hDD79288D;
  int error_cnt = 0;
  int n_checks = 0;
  wake_act_type exp_q[$];
  mode_type md[4] = '{ST_SLEEP, ST_IDLE0, ST_IDLE2, ST_IDLE1};

  initial forever #2.5 mclk_i = ~mclk_i;

  power_mode_wake_control #(.HS_SETTLE(HS), .LS_SETTLE(LS)) u_dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .sys_clk_sel_i(sel),
    .hs_osc_keep_on_halt_i(hk), .ls_osc_keep_on_halt_i(lk),
    .hs_osc_enable_i(hen), .hs_freq_change_i(fchg),
    .porta_wake_enable_i(wen), .porta_pin_i(pin), .halt_instr_i(halt),
    .watchdog_clear_instr_i(clr), .irq_req_i(irq), .irq_enabled_i(ien),
    .stack_full_i(sfull), .wdt_overflow_i(ovf), .mode_o(mode),
    .cpu_run_o(run), .hs_osc_on_o(hon), .ls_osc_on_o(lon),
    .sys_clk_en_o(cen), .sys_is_sub_o(sub), .div_sel_o(div),
    .hs_osc_stable_flag_o(stb), .power_down_flag_o(pdn),
    .wdt_timeout_flag_o(tmo), .wdt_clear_o(wclr), .pc_sp_reset_o(pcsp),
    .irq_take_o(take), .resume_o(res));

  core_model u_core (.mclk_i(mclk_i), .cpu_run_i(run), .hs_stable_i(stb),
    .halt_o(halt), .clr_o(clr), .ovf_o(ovf));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %0h expected %0h", $time, s, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc

  task automatic wait_for(input int w);
    int n;
    n = 0;
    while (((w == 0 && run !== 1'b1) || (w == 1 && stb !== 1'b1)) &&
           n < 300) begin
      cyc(1);
      n++;
    end
  endtask : wait_for

  task automatic do_halt(input logic h, input logic l, input mode_type m);
    hk = h;
    lk = l;
    u_core.halt();
    chk(mode, m);
    chk({run, cen}, 2'h0);
    chk(wclr, 1'b1);
    chk({pdn, tmo}, 2'h2);
    cyc(1);
    chk({hon, lon}, {h, l});
  endtask : do_halt

  task automatic wrap_up();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // a wake result with no pending note is a wake the bench did not expect
  always @(negedge mclk_i) begin
    if (srst_i === 1'b0 && (pcsp | take | res) === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h0, 32'h1);
      else chk({pcsp, take, res}, exp_q.pop_front());
    end
  end

  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    sel = 3'h0; hk = 1'b0; lk = 1'b0; hen = 1'b0; fchg = 1'b0;
    wen = 4'h0; pin = 4'hF; irq = 1'b0; ien = 1'b0; sfull = 1'b0;
    cyc(12);
    srst_i = 1'b0;
    for (int c = 0; c < 7; c++) begin
      sel = c[2:0];
      cyc(3);
      chk({sub, div}, {1'b0, DIV_W'(1 << c)});
    end
    sel = CLK_SEL_SUB;
    cyc(LS + 4);
    chk({mode, sub}, {ST_SLOW, 1'b1});
    cyc(HS + 2);
    chk(hon, 1'b0);
    hen = 1'b1;
    cyc(2);
    chk({hon, stb}, 2'h2);
    wait_for(1);
    chk({mode, stb}, {ST_SLOW, 1'b1});
    hen = 1'b0;
    cyc(2);
    sel = 3'h0;
    cyc(1);
    chk(stb, 1'b0);
    wait_for(1);
    cyc(2);
    chk({mode, sub, stb}, {ST_FAST, 2'h1});
    fchg = 1'b1;
    cyc(1);
    fchg = 1'b0;
    cyc(1);
    chk(stb, 1'b0);
    wait_for(1);
    chk(stb, 1'b1);
    irq = 1'b1;
    ien = 1'b1;
    do_halt(1'b0, 1'b0, ST_SLEEP);
    cyc(10);
    chk(mode, ST_SLEEP);
    exp_q.push_back(wake_act_type'(3'h4));
    u_core.ovf();
    irq = 1'b0;
    wait_for(0);
    chk({tmo, pdn}, 2'h3);
    u_core.clr();
    cyc(2);
    chk(pdn, 1'b0);
    for (int k = 0; k < 3; k++) begin
      ien = (k != 1);
      sfull = (k == 2);
      do_halt(1'b1, 1'b1, ST_IDLE1);
      exp_q.push_back(wake_act_type'(k == 0 ? 3'h2 : 3'h1));
      irq = 1'b1;
      wait_for(0);
      irq = 1'b0;
      cyc(2);
    end
    for (int k = 0; k < 4; k++) begin
      rng = xs(rng);
      p = rng[1:0];
      q = p + 2'h1;
      wen = 4'h1 << p;
      do_halt(k[1], k[0], md[k]);
      pin[q] = 1'b0;
      cyc(8);
      chk(run, 1'b0);
      exp_q.push_back(wake_act_type'(3'h1));
      pin[p] = 1'b0;
      wait_for(0);
      chk({mode, pdn}, {ST_FAST, 1'b1});
      pin = 4'hF;
      cyc(2);
    end
    srst_i = 1'b1;
    cyc(2);
    chk({mode, pdn}, {ST_FAST, 1'b0});
    srst_i = 1'b0;
    cyc(2);
    chk(exp_q.size(), 0);
    wrap_up();
  end
endmodule : power_mode_wake_control_test
